// [include/slt_pkg.sv]
package slt_pkg;
	// Register indices as printed; byte address is four times the index
	localparam logic [9:0] IDX_TS_MARKER = 10'h160;
	localparam logic [9:0] IDX_LINK_EN = 10'h200;
	localparam logic [9:0] IDX_MODE = 10'h201;
	localparam logic [9:0] IDX_KM1 = 10'h202;
	localparam logic [9:0] IDX_LINK_CTRL = 10'h210;
	localparam logic [9:0] IDX_MODE_LIMIT = 10'h211;
	localparam logic [9:0] IDX_STATUS = 10'h212;
	// Reset values
	localparam logic [7:0] RST_TS_MARKER = 8'h00;
	localparam logic [7:0] RST_LINK_EN = 8'h01;
	localparam logic [7:0] RST_MODE = 8'h02;
	localparam logic [7:0] RST_KM1 = 8'h1f;
	localparam logic [7:0] RST_LINK_CTRL = 8'h00;
	localparam logic [7:0] RST_MODE_LIMIT = 8'hff;
	// Field positions
	localparam int TS_EN_BIT = 0;
	localparam int LINK_EN_BIT = 0;
	localparam int CAL_EN_BIT = 0;
	localparam int SYNC_RX_EN_BIT = 1;
	localparam int ST_ACTIVE_BIT = 0;
	localparam int ST_66B_BIT = 1;
	localparam int ST_REFUSED_BIT = 2;
	localparam int ST_K_LSB = 8;
	localparam int LSB_8BIT_POS = 4;
	localparam int LSB_12BIT_POS = 0;
	// Timing: analog path latency from pin to sample port, in cycles
	localparam int SYNC_STAGES = 2;
	localparam int ADC_PATH_LAT_CYC = 8;
	localparam int TS_DELAY_DEPTH = ADC_PATH_LAT_CYC - SYNC_STAGES;
	localparam logic [8:0] K66_SCALE = 9'h100;
endpackage

// [rtl/slt_ts_delay.sv]
`timescale 1ns/1ps
// Shift line that lines the timestamp up with the sample path
module slt_ts_delay #(
	parameter int DEPTH = 6
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic din,
	output logic dout
);
	logic [DEPTH-1:0] stage;

	// One flop per cycle of delay
	genvar g;
	generate
		for (g = 0; g < DEPTH; g++) begin : g_stage
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					stage[g] <= 1'b0;
				end else begin
					stage[g] <= (g == 0) ? din : stage[(g == 0) ? 0 : g-1];
				end
			end
		end
	endgenerate

	assign dout = stage[DEPTH-1];
endmodule

// [rtl/slt_link_config.sv]
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
//Behaviour
//- With timestamp insertion set, timestamp rides on the LSB of every sample.
//- Timestamp is delayed exactly as much as the analog samples.
//- In 8-bit modes the marker takes the 8-bit sample's LSB, 7 data bits remain.
//- In 12-bit modes the marker takes bit 0, 11 data bits remain.
//- Lane alignment sequence never announces the marker; CS stays zero.
//- Link enable bit: 0 disables, 1 enables; resets to 1.
//- Disabled link is held in reset with serializers powered down.
//- Disabled link has its clocks gated off.
//- Disabled link holds multiframe counter in reset and ignores SYSREF.
//- Eight-bit mode code selects the link mode; resets to two.
//- Only mode codes allowed by the restriction setting are accepted.
//- Multiframe length field holds frames minus one; resets to 31 (K=32).
//- In 64b/66b modes K comes from the mode as 256*E/F, field ignored.
module slt_link_config
	import slt_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic mode_is_66b,
	input wire logic mode_8bit,
	input wire logic [7:0] mode_e,
	input wire logic [7:0] mode_f,
	input wire logic [11:0] sample_in,
	input wire logic sample_valid,
	input wire logic timestamp_pin,
	input wire logic sysref_pin,
	input wire logic frame_tick,
	output logic [11:0] sample_out,
	output logic sample_out_valid,
	output logic link_reset_n,
	output logic serializer_power_down,
	output logic link_clock_enable,
	output logic cal_enable,
	output logic sync_receiver_enable,
	output logic [7:0] link_mode_code,
	output logic [15:0] k_effective_minus_one,
	output logic [1:0] ila_control_bits,
	output logic [15:0] multiframe_clock_counter,
	output logic multiframe_boundary
);
	logic [7:0] ts_ctrl;
	logic [7:0] link_en_reg;
	logic [7:0] km1;
	logic [7:0] mode_limit;
	logic mode_refused;
	logic [9:0] idx;
	logic setup;
	logic commit_wr;
	logic timestamp_insert_enable;
	logic serial_link_enable;
	logic mode_allowed;
	logic ts_meta;
	logic ts_sync;
	logic ts_aligned;
	logic sr_meta;
	logic sr_sync;
	logic sr_prev;
	logic sysref_edge;
	logic [16:0] k66;
	logic [15:0] next_k_m1;
	logic [31:0] next_rdata;
	logic next_err;

	// Assertion clock and reset
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	assign idx = paddr[11:2];
	assign setup = psel && !penable;
	assign commit_wr = psel && penable && pready && pwrite;
	assign timestamp_insert_enable = ts_ctrl[TS_EN_BIT];
	assign serial_link_enable = link_en_reg[LINK_EN_BIT];
	assign mode_allowed = pwdata[7:0] <= mode_limit;

	// Zero-wait slave: answer is prepared in setup, pready high in access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready <= setup;
			if (setup) begin
				prdata <= pwrite ? 32'h0000_0000 : next_rdata;
				pslverr <= next_err;
			end
		end
	end

	// Read decode; unmapped indices answer zero with an error
	always_comb begin
		next_rdata = 32'h0000_0000;
		next_err = 1'b0;
		unique case (idx)
			IDX_TS_MARKER: next_rdata = {24'h00_0000, ts_ctrl};
			IDX_LINK_EN: next_rdata = {24'h00_0000, link_en_reg};
			IDX_MODE: next_rdata = {24'h00_0000, link_mode_code};
			IDX_KM1: next_rdata = {24'h00_0000, km1};
			IDX_LINK_CTRL: next_rdata = {30'h0000_0000, sync_receiver_enable, cal_enable};
			IDX_MODE_LIMIT: next_rdata = {24'h00_0000, mode_limit};
			IDX_STATUS: begin
				next_rdata[ST_ACTIVE_BIT] = link_reset_n;
				next_rdata[ST_66B_BIT] = mode_is_66b;
				next_rdata[ST_REFUSED_BIT] = mode_refused;
				next_rdata[ST_K_LSB +: 16] = k_effective_minus_one;
			end
			default: next_err = 1'b1;
		endcase
	end

	// Plain read/write configuration registers; reserved bits hold what is written, except in LINK_CTRL where bits 7:2 read zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ts_ctrl <= RST_TS_MARKER;
			link_en_reg <= RST_LINK_EN;
			km1 <= RST_KM1;
			mode_limit <= RST_MODE_LIMIT;
			cal_enable <= RST_LINK_CTRL[CAL_EN_BIT];
			sync_receiver_enable <= RST_LINK_CTRL[SYNC_RX_EN_BIT];
		end else if (commit_wr) begin
			unique case (idx)
				IDX_TS_MARKER: ts_ctrl <= pwdata[7:0];
				IDX_LINK_EN: link_en_reg <= pwdata[7:0];
				IDX_KM1: km1 <= pwdata[7:0];
				IDX_MODE_LIMIT: mode_limit <= pwdata[7:0];
				IDX_LINK_CTRL: begin
					cal_enable <= pwdata[CAL_EN_BIT];
					sync_receiver_enable <= pwdata[SYNC_RX_EN_BIT];
				end
				default: ;
			endcase
		end
	end

	// Mode code: a disallowed code is dropped and flagged
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			link_mode_code <= RST_MODE;
			mode_refused <= 1'b0;
		end else if (commit_wr && idx == IDX_MODE) begin
			mode_refused <= !mode_allowed;
			if (mode_allowed) begin
				link_mode_code <= pwdata[7:0];
			end
		end
	end

	// Link control outputs follow the enable bit one cycle later
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			link_reset_n <= 1'b0;
			serializer_power_down <= 1'b1;
			link_clock_enable <= 1'b0;
			ila_control_bits <= 2'h0;
		end else begin
			link_reset_n <= serial_link_enable;
			serializer_power_down <= !serial_link_enable;
			link_clock_enable <= serial_link_enable;
			ila_control_bits <= 2'h0;
		end
	end

	// Effective frames per multiframe, minus one
	assign k66 = ({9'h000, mode_e} * {8'h00, K66_SCALE}) / {9'h000, mode_f};
	always_comb begin
		if (mode_is_66b) begin
			next_k_m1 = (mode_f == 8'h00) ? 16'h0000 : 16'(k66 - 17'h00001);
		end else begin
			next_k_m1 = {8'h00, km1};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			k_effective_minus_one <= {8'h00, RST_KM1};
		end else begin
			k_effective_minus_one <= next_k_m1;
		end
	end

	// Pin synchronisers for timestamp and SYSREF
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ts_meta <= 1'b0;
			ts_sync <= 1'b0;
			sr_meta <= 1'b0;
			sr_sync <= 1'b0;
			sr_prev <= 1'b0;
		end else begin
			ts_meta <= timestamp_pin;
			ts_sync <= ts_meta;
			sr_meta <= sysref_pin;
			sr_sync <= sr_meta;
			sr_prev <= sr_sync;
		end
	end

	assign sysref_edge = sr_sync && !sr_prev;

	// Extra delay so the marker meets its sample at the output
	slt_ts_delay #(
		.DEPTH(TS_DELAY_DEPTH)
	) u_ts_delay (
		.pclk(pclk),
		.presetn(presetn),
		.din(ts_sync),
		.dout(ts_aligned)
	);

	// Output sample stage with optional marker insertion
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sample_out <= 12'h000;
			sample_out_valid <= 1'b0;
		end else begin
			sample_out_valid <= sample_valid && serial_link_enable;
			sample_out <= sample_in;
			if (timestamp_insert_enable) begin
				if (mode_8bit) begin
					sample_out[LSB_8BIT_POS] <= ts_aligned;
				end else begin
					sample_out[LSB_12BIT_POS] <= ts_aligned;
				end
			end
		end
	end

	// Multiframe counter: cleared while disabled, realigned by SYSREF
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			multiframe_clock_counter <= 16'h0000;
			multiframe_boundary <= 1'b0;
		end else if (!serial_link_enable) begin
			multiframe_clock_counter <= 16'h0000;
			multiframe_boundary <= 1'b0;
		end else if (sysref_edge) begin
			multiframe_clock_counter <= 16'h0000;
			multiframe_boundary <= 1'b1;
		end else if (frame_tick) begin
			if (multiframe_clock_counter >= k_effective_minus_one) begin
				multiframe_clock_counter <= 16'h0000;
				multiframe_boundary <= 1'b1;
			end else begin
				multiframe_clock_counter <= multiframe_clock_counter + 16'h0001;
				multiframe_boundary <= 1'b0;
			end
		end else begin
			multiframe_boundary <= 1'b0;
		end
	end

	// Checks
	localparam int TS_TOTAL = ADC_PATH_LAT_CYC + 1;

	sequence s_mode_write;
		psel && penable && pready && pwrite && idx == IDX_MODE;
	endsequence

	sequence s_setup;
		psel && !penable;
	endsequence

	sequence s_link_write;
		psel && penable && pready && pwrite && idx == IDX_LINK_EN;
	endsequence

	a_ts_lsb_twelve: assert property (
		$past(timestamp_insert_enable) && !$past(mode_8bit) && sample_out_valid
		|-> sample_out[0] == $past(timestamp_pin, TS_TOTAL) && sample_out[11:1] == $past(sample_in[11:1])
	) else $error("timestamp missing from 12-bit sample LSB");

	a_ts_lsb_eight: assert property (
		$past(timestamp_insert_enable) && $past(mode_8bit) && sample_out_valid
		|-> sample_out[4] == $past(timestamp_pin, TS_TOTAL) && sample_out[11:5] == $past(sample_in[11:5])
	) else $error("timestamp missing from 8-bit sample LSB");

	a_ts_off_pass: assert property (
		!$past(timestamp_insert_enable) && sample_out_valid |-> sample_out == $past(sample_in)
	) else $error("sample altered with timestamp off");

	a_ila_cs_zero: assert property (
		ila_control_bits == 2'h0
	) else $error("control bits announced");

	a_link_hold_off: assert property (
		!serial_link_enable |=> !link_reset_n && serializer_power_down && !link_clock_enable
	) else $error("disabled link not held");

	a_mfc_hold_reset: assert property (
		!serial_link_enable ##1 !serial_link_enable |-> multiframe_clock_counter == 16'h0000
	) else $error("multiframe counter runs while disabled");

	a_mode_refuse_bad: assert property (
		s_mode_write ##0 (pwdata[7:0] > mode_limit) |=> $stable(link_mode_code) && mode_refused
	) else $error("disallowed mode code accepted");

	a_mode_take_good: assert property (
		s_mode_write ##0 (pwdata[7:0] <= mode_limit) |=> link_mode_code == $past(pwdata[7:0])
	) else $error("allowed mode code not taken");

	a_k_from_field: assert property (
		!mode_is_66b |=> k_effective_minus_one == {8'h00, $past(km1)}
	) else $error("K minus one not from field");

	a_k_from_mode: assert property (
		mode_is_66b && mode_f == 8'h04 && mode_e == 8'h01 |=> k_effective_minus_one == 16'h003f
	) else $error("64b/66b K not 256*E/F");

	a_apb_ready_once: assert property (
		s_setup |=> pready ##1 !pready || (psel && !penable)
	) else $error("pready not one cycle after setup");

	// Sampled reset in the antecedent skips the release edge, where the outputs are still in reset
	a_link_run_on: assert property (
		presetn && serial_link_enable
		|=> link_reset_n && !serializer_power_down && link_clock_enable
	) else $error("enabled link not released");

	a_link_write_take: assert property (
		s_link_write |=> link_en_reg == $past(pwdata[7:0])
	) else $error("link enable write lost");

	a_mfc_sysref_align: assert property (
		serial_link_enable && sysref_edge |=> multiframe_clock_counter == 16'h0000 && multiframe_boundary
	) else $error("SYSREF did not realign counter");

	a_mfc_count_step: assert property (
		serial_link_enable && !sysref_edge && frame_tick && multiframe_clock_counter < k_effective_minus_one
		|=> multiframe_clock_counter == $past(multiframe_clock_counter) + 16'h0001
	) else $error("counter did not advance on frame tick");
endmodule

// [bench/serial_link_config_and_timestamp_tb.sv]
`timescale 1ns/1ps
module serial_link_config_and_timestamp_tb
	import slt_pkg::*;
;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, err;
	logic mode_is_66b = 1'b0, mode_8bit = 1'b0;
	logic [7:0] mode_e = 8'h01, mode_f = 8'h04;
	logic [11:0] sample_in = 12'h000, sample_out;
	logic sample_valid = 1'b0, timestamp_pin = 1'b0, sysref_pin = 1'b0, frame_tick = 1'b0;
	logic sample_out_valid, link_reset_n, serializer_power_down, link_clock_enable;
	logic cal_enable, sync_receiver_enable, multiframe_boundary;
	logic [7:0] link_mode_code;
	logic [15:0] k_effective_minus_one, multiframe_clock_counter;
	logic [1:0] ila_control_bits;
	int mismatches = 0;
	int comparisons = 0;
	int lat;

	slt_link_config u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.mode_is_66b(mode_is_66b), .mode_8bit(mode_8bit), .mode_e(mode_e), .mode_f(mode_f),
		.sample_in(sample_in), .sample_valid(sample_valid), .timestamp_pin(timestamp_pin),
		.sysref_pin(sysref_pin), .frame_tick(frame_tick), .sample_out(sample_out),
		.sample_out_valid(sample_out_valid), .link_reset_n(link_reset_n),
		.serializer_power_down(serializer_power_down), .link_clock_enable(link_clock_enable),
		.cal_enable(cal_enable), .sync_receiver_enable(sync_receiver_enable),
		.link_mode_code(link_mode_code), .k_effective_minus_one(k_effective_minus_one),
		.ila_control_bits(ila_control_bits), .multiframe_clock_counter(multiframe_clock_counter),
		.multiframe_boundary(multiframe_boundary));

	// 25 MHz clock
	always #20 pclk = ~pclk;

	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// One APB transfer; waits for pready under a bound
	task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		for (n = 0; n < 20; n++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		if (n == 20) begin
			mismatches++;
			stop_test();
		end else begin
			rd = prdata;
			err = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask

	// Reads a register and compares its value and error flag
	task automatic rchk(input string name, input logic [9:0] idx, input logic [31:0] exp, input logic eerr);
		apb(1'b0, idx, 32'h0);
		check(name, rd, exp);
		check({name, "_err"}, {31'h0, err}, {31'h0, eerr});
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask

	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rchk("ts_marker", IDX_TS_MARKER, 32'h00, 1'b0);
		rchk("link_en", IDX_LINK_EN, 32'h01, 1'b0);
		rchk("mode", IDX_MODE, 32'h02, 1'b0);
		rchk("km1", IDX_KM1, 32'h1f, 1'b0);
		rchk("unmapped", 10'h3ff, 32'h0, 1'b1);
		settle(1);
		check("link_rst_on", {31'h0, link_reset_n}, 32'h1);
		check("k_reset", {16'h0, k_effective_minus_one}, 32'h1f);
		// Disable the link, then tick frames and pulse SYSREF
		apb(1'b1, IDX_LINK_EN, 32'h0);
		@(posedge pclk);
		sample_valid <= 1'b1;
		frame_tick <= 1'b1;
		sysref_pin <= 1'b1;
		settle(6);
		check("link_rst_off", {31'h0, link_reset_n}, 32'h0);
		check("ser_pd", {31'h0, serializer_power_down}, 32'h1);
		check("clk_en", {31'h0, link_clock_enable}, 32'h0);
		check("valid_off", {31'h0, sample_out_valid}, 32'h0);
		check("cnt_held", {16'h0, multiframe_clock_counter}, 32'h0);
		check("bnd_held", {31'h0, multiframe_boundary}, 32'h0);
		@(posedge pclk);
		frame_tick <= 1'b0;
		sysref_pin <= 1'b0;
		// Mode restriction: code above the limit is refused
		apb(1'b1, IDX_MODE_LIMIT, 32'h05);
		apb(1'b1, IDX_MODE, 32'h09);
		rchk("mode_refused", IDX_MODE, 32'h02, 1'b0);
		apb(1'b0, IDX_STATUS, 32'h0);
		check("refused_flag", {31'h0, rd[ST_REFUSED_BIT]}, 32'h1);
		apb(1'b1, IDX_MODE, 32'h05);
		rchk("mode_ok", IDX_MODE, 32'h05, 1'b0);
		check("mode_out", {24'h0, link_mode_code}, 32'h05);
		apb(1'b1, IDX_KM1, 32'h03);
		settle(2);
		check("k_field", {16'h0, k_effective_minus_one}, 32'h03);
		@(posedge pclk);
		mode_is_66b <= 1'b1;
		settle(3);
		check("k_66b", {16'h0, k_effective_minus_one}, 32'd63);
		check("ila_cs", {30'h0, ila_control_bits}, 32'h0);
		@(posedge pclk);
		mode_is_66b <= 1'b0;
		// Calibration and sync receiver first, then the link
		apb(1'b1, IDX_LINK_CTRL, 32'h03);
		apb(1'b1, IDX_LINK_EN, 32'h01);
		apb(1'b1, IDX_TS_MARKER, 32'h01);
		settle(2);
		check("sync_rx", {31'h0, sync_receiver_enable}, 32'h1);
		check("valid_on", {31'h0, sample_out_valid}, 32'h1);
		check("link_rst_back", {31'h0, link_reset_n}, 32'h1);
		check("ser_pu", {31'h0, serializer_power_down}, 32'h0);
		check("clk_on", {31'h0, link_clock_enable}, 32'h1);
		check("cal_on", {31'h0, cal_enable}, 32'h1);
		rchk("link_ctrl", IDX_LINK_CTRL, 32'h03, 1'b0);
		// Counter wraps after K frames with K-1 = 3
		@(posedge pclk);
		frame_tick <= 1'b1;
		settle(2);
		check("cnt_two", {16'h0, multiframe_clock_counter}, 32'h2);
		repeat (2) @(posedge pclk);
		frame_tick <= 1'b0;
		#1;
		check("cnt_wrap", {16'h0, multiframe_clock_counter}, 32'h0);
		check("bnd_wrap", {31'h0, multiframe_boundary}, 32'h1);
		// SYSREF realigns a running counter three edges after the pin rises
		@(posedge pclk);
		frame_tick <= 1'b1;
		@(posedge pclk);
		frame_tick <= 1'b0;
		sysref_pin <= 1'b1;
		settle(1);
		check("cnt_one", {16'h0, multiframe_clock_counter}, 32'h1);
		settle(2);
		check("cnt_align", {16'h0, multiframe_clock_counter}, 32'h0);
		check("bnd_align", {31'h0, multiframe_boundary}, 32'h1);
		// Marker latency in twelve-bit mode
		@(posedge pclk);
		sysref_pin <= 1'b0;
		sample_in <= 12'habe;
		timestamp_pin <= 1'b1;
		lat = 0;
		for (int i = 1; i <= 20; i++) begin
			@(posedge pclk);
			#1;
			if (sample_out[0] === 1'b1 && lat == 0) lat = i;
		end
		check("ts_latency", lat, 32'd9);
		check("ts_12bit", {20'h0, sample_out}, 32'habf);
		@(posedge pclk);
		mode_8bit <= 1'b1;
		sample_in <= 12'ha00;
		settle(2);
		check("ts_8bit", {20'h0, sample_out}, 32'ha10);
		@(posedge pclk);
		timestamp_pin <= 1'b0;
		settle(12);
		check("ts_low", {20'h0, sample_out}, 32'ha00);
		// Shutdown: link off before calibration
		apb(1'b1, IDX_LINK_EN, 32'h0);
		apb(1'b1, IDX_LINK_CTRL, 32'h0);
		settle(1);
		check("link_rst_end", {31'h0, link_reset_n}, 32'h0);
		check("cal_off", {31'h0, cal_enable}, 32'h0);
		stop_test();
	end

	// Run-length guard
	initial begin
		#1000000;
		mismatches++;
		stop_test();
	end
endmodule
